/* File: design/fsps_pkg.sv */
// Shared constants and types of the flash self-programming sequencer
package fsps_pkg;

  // ==========================================================================
  // Register map (byte addresses on the APB)
  localparam logic [7:0] FSPS_OFS_CTRL = 8'h00;
  localparam logic [7:0] FSPS_OFS_KEY  = 8'h04;
  localparam logic [7:0] FSPS_OFS_PTR  = 8'h08;
  localparam logic [7:0] FSPS_OFS_TWL  = 8'h0C;
  localparam logic [7:0] FSPS_OFS_TWH  = 8'h10;

  // ==========================================================================
  // Control register fields
  localparam int unsigned FSPS_CTRL_GO    = 15;
  localparam int unsigned FSPS_CTRL_OP_WRITE_ENABLE  = 14;
  localparam int unsigned FSPS_CTRL_ERR   = 13;
  localparam int unsigned FSPS_CTRL_ERASE = 6;
  localparam int unsigned FSPS_OP_W       = 4;
  localparam logic [15:0] FSPS_CTRL_RESET = 16'h0000;

  // ==========================================================================
  // Unlock key values, written in this order
  localparam logic [7:0] FSPS_KEY_FIRST  = 8'h55;
  localparam logic [7:0] FSPS_KEY_SECOND = 8'hAA;

  // ==========================================================================
  // Operation select codes
  localparam logic [3:0] FSPS_OP_BULK = 4'hF;
  localparam logic [3:0] FSPS_OP_PAGE = 4'h2;
  localparam logic [3:0] FSPS_OP_ROW  = 4'h1;
  localparam logic [3:0] FSPS_OP_WORD = 4'h3;
  localparam logic [3:0] FSPS_OP_CFG  = 4'h0;
  localparam logic [3:0] FSPS_OP_NOPE = 4'h3;  // Erase side no-op
  localparam logic [3:0] FSPS_OP_NOPP = 4'hF;  // Program side no-op

  // ==========================================================================
  // Array geometry
  localparam int unsigned FSPS_ROW_WORDS  = 64;
  localparam int unsigned FSPS_PAGE_ROWS  = 8;
  localparam int unsigned FSPS_ROW_BYTES  = 192;
  localparam int unsigned FSPS_PAGE_BYTES = 1536;
  localparam int unsigned FSPS_WORD_BITS  = 24;
  localparam int unsigned FSPS_ROW_LSB    = $clog2(FSPS_ROW_WORDS);
  localparam int unsigned FSPS_PAGE_LSB   = $clog2(FSPS_ROW_WORDS * FSPS_PAGE_ROWS);

  // ==========================================================================
  // Timing: operation length counted in internal oscillator cycles
  localparam int unsigned FSPS_CLK_KHZ   = 100000;
  localparam int unsigned FSPS_FRC_KHZ   = 7370;
  localparam int unsigned FSPS_ROW_TICKS = 11064;
  localparam int unsigned FSPS_TICK_W    = 20;

  typedef enum logic [1:0] {FSPS_IDLE, FSPS_WRITE, FSPS_WAIT} fsps_state_e;
  typedef enum logic [2:0] {
    FSPS_K_NONE, FSPS_K_BAD, FSPS_K_ROW, FSPS_K_WORD, FSPS_K_CFG, FSPS_K_PAGE, FSPS_K_BULK
  } fsps_kind_e;

endpackage

/* File: design/fsps_sequencer.sv */
// Flash self-programming sequencer: APB registers, holding buffer, timed operations
`timescale 1ns/1ps

// Behaviour
// - Rows hold sixty-four 24-bit instruction words
// - Page erase clears eight rows at once
// - Program one row or one word
// - Pages and rows aligned to array start
// - Sixty-four word holding buffer, filled in order
// - Table writes touch buffer only, two cycles
// - One programming cycle per row
// - Processor stalled until operation finishes
// - Duration counted in internal oscillator cycles
// - Go bit starts; hardware clears it at end
// - Key byte write-only, reads zero
// - Operation code plus erase bit selects action
module fsps_sequencer #(
  parameter int unsigned AW         = 16,
  parameter int unsigned ROW_TICKS  = fsps_pkg::FSPS_ROW_TICKS,
  parameter int unsigned WORD_TICKS = 2000,
  parameter int unsigned PAGE_TICKS = 12000,
  parameter int unsigned BULK_TICKS = 24000
) (
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            other_rst_n,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [7:0]      paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  output logic                 cpu_stall,
  output logic                 arr_we,
  output logic                 arr_cfg,
  output logic                 arr_erase,
  output logic                 arr_erase_all,
  output logic      [AW-1:0]   arr_addr,
  output logic      [23:0]     arr_wdata
);
  import fsps_pkg::*;

  localparam int unsigned RL = FSPS_ROW_LSB;
  localparam int unsigned PL = FSPS_PAGE_LSB;

  // Refuse widths the address split cannot serve
  if (AW <= PL || AW > 32 || ROW_TICKS == 0 || WORD_TICKS == 0 || PAGE_TICKS == 0 ||
      BULK_TICKS == 0 || BULK_TICKS >= (1 << FSPS_TICK_W) ||
      ROW_TICKS >= (1 << FSPS_TICK_W) || PAGE_TICKS >= (1 << FSPS_TICK_W) ||
      WORD_TICKS >= (1 << FSPS_TICK_W)) begin : g_bad_param
    $error("fsps_sequencer: unsupported parameter values");
  end

  // ==========================================================================
  // Register state
  logic                   go_q, op_write_enable_q, err_q, erase_q;
  logic [FSPS_OP_W-1:0]   op_q;
  logic [1:0]             key_st_q;
  logic [AW-1:0]          ptr_q, last_q;
  logic [23:0]            buf_q [FSPS_ROW_WORDS];
  fsps_state_e            st_q;
  fsps_kind_e             kind_q, wkind;
  logic [RL-1:0]          idx_q;
  logic [FSPS_TICK_W-1:0] tick_cnt_q, tick_lim;
  logic [FSPS_TICK_W-1:0] acc_q;
  logic                   frc_tick;

  // ==========================================================================
  // APB decode
  logic wr_en, rd_en, hit, go_req, go_ok, err_set, done;
  assign pready    = ~go_q;
  assign cpu_stall = go_q;
  assign wr_en     = psel & penable & pwrite & pready;
  assign rd_en     = psel & penable & ~pwrite & pready;
  assign hit       = (paddr == FSPS_OFS_CTRL) || (paddr == FSPS_OFS_KEY) ||
                     (paddr == FSPS_OFS_PTR) || (paddr == FSPS_OFS_TWL) ||
                     (paddr == FSPS_OFS_TWH);
  assign pslverr   = psel & penable & ~hit;

  // Decode the operation carried by the control write itself
  always_comb begin
    wkind = FSPS_K_BAD;
    if (pwdata[FSPS_CTRL_ERASE]) begin
      if (pwdata[3:0] == FSPS_OP_BULK) wkind = FSPS_K_BULK;
      else if (pwdata[3:0] == FSPS_OP_PAGE) wkind = FSPS_K_PAGE;
      else if (pwdata[3:0] == FSPS_OP_CFG) wkind = FSPS_K_CFG;
      else if (pwdata[3:0] == FSPS_OP_NOPE) wkind = FSPS_K_NONE;
    end else begin
      if (pwdata[3:0] == FSPS_OP_ROW) wkind = FSPS_K_ROW;
      else if (pwdata[3:0] == FSPS_OP_WORD) wkind = FSPS_K_WORD;
      else if (pwdata[3:0] == FSPS_OP_CFG) wkind = FSPS_K_CFG;
      else if (pwdata[3:0] == FSPS_OP_NOPP) wkind = FSPS_K_NONE;
    end
  end

  // A go needs the unlock just before, write enable, and a real code
  assign go_req  = wr_en && (paddr == FSPS_OFS_CTRL) && pwdata[FSPS_CTRL_GO];
  assign go_ok   = go_req && (key_st_q == 2'd2) && pwdata[FSPS_CTRL_OP_WRITE_ENABLE] &&
                   (wkind != FSPS_K_BAD) && (wkind != FSPS_K_NONE);
  assign err_set = go_req && ((key_st_q != 2'd2) || !pwdata[FSPS_CTRL_OP_WRITE_ENABLE] ||
                   (wkind == FSPS_K_BAD));

  // ==========================================================================
  // Control register; only power-on reset returns it to default
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      go_q    <= FSPS_CTRL_RESET[FSPS_CTRL_GO];
      op_write_enable_q  <= FSPS_CTRL_RESET[FSPS_CTRL_OP_WRITE_ENABLE];
      erase_q <= FSPS_CTRL_RESET[FSPS_CTRL_ERASE];
      op_q    <= FSPS_CTRL_RESET[FSPS_OP_W-1:0];
      kind_q  <= FSPS_K_NONE;
    end else begin
      if (wr_en && paddr == FSPS_OFS_CTRL) begin
        op_write_enable_q  <= pwdata[FSPS_CTRL_OP_WRITE_ENABLE];
        erase_q <= pwdata[FSPS_CTRL_ERASE];
        op_q    <= pwdata[FSPS_OP_W-1:0];
      end
      if (go_ok) begin
        go_q   <= 1'b1;
        kind_q <= wkind;
      end else if (done) begin
        go_q   <= 1'b0;
      end
    end
  end

  // Error flag: hardware set beats a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_q <= FSPS_CTRL_RESET[FSPS_CTRL_ERR];
    end else if (err_set) begin
      err_q <= 1'b1;
    end else if (wr_en && paddr == FSPS_OFS_CTRL) begin
      err_q <= pwdata[FSPS_CTRL_ERR];
    end
  end

  // ==========================================================================
  // Unlock sequence: any other write in between breaks it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_st_q <= 2'd0;
    end else if (!other_rst_n) begin
      key_st_q <= 2'd0;
    end else if (wr_en) begin
      if (paddr == FSPS_OFS_KEY && pwdata[7:0] == FSPS_KEY_FIRST) begin
        key_st_q <= 2'd1;
      end else if (paddr == FSPS_OFS_KEY && pwdata[7:0] == FSPS_KEY_SECOND &&
                   key_st_q == 2'd1) begin
        key_st_q <= 2'd2;
      end else begin
        key_st_q <= 2'd0;
      end
    end
  end

  // ==========================================================================
  // Table pointer; a high-word write advances it to the next word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_q  <= '0;
      last_q <= '0;
    end else if (!other_rst_n) begin
      ptr_q  <= '0;
      last_q <= '0;
    end else if (wr_en && paddr == FSPS_OFS_PTR) begin
      ptr_q  <= pwdata[AW-1:0];
      last_q <= pwdata[AW-1:0];
    end else if (wr_en && paddr == FSPS_OFS_TWH) begin
      ptr_q  <= ptr_q + 1'b1;
      last_q <= ptr_q;
    end
  end

  // Holding buffer: table writes land here, never in the array
  for (genvar i = 0; i < FSPS_ROW_WORDS; i++) begin : g_buf
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        buf_q[i] <= '0;
      end else if (wr_en && ptr_q[RL-1:0] == RL'(i)) begin
        if (paddr == FSPS_OFS_TWL) buf_q[i][15:0] <= pwdata[15:0];
        if (paddr == FSPS_OFS_TWH) buf_q[i][23:16] <= pwdata[7:0];
      end
    end
  end

  // ==========================================================================
  // Read mux; key byte never reads back
  always_comb begin
    prdata = '0;
    if (rd_en && paddr == FSPS_OFS_CTRL) begin
      prdata[FSPS_CTRL_GO]    = go_q;
      prdata[FSPS_CTRL_OP_WRITE_ENABLE]  = op_write_enable_q;
      prdata[FSPS_CTRL_ERR]   = err_q;
      prdata[FSPS_CTRL_ERASE] = erase_q;
      prdata[FSPS_OP_W-1:0]   = op_q;
    end else if (rd_en && paddr == FSPS_OFS_PTR) begin
      prdata[AW-1:0] = ptr_q;
    end else if (rd_en && paddr == FSPS_OFS_TWL) begin
      prdata[15:0] = buf_q[ptr_q[RL-1:0]][15:0];
    end else if (rd_en && paddr == FSPS_OFS_TWH) begin
      prdata[7:0] = buf_q[ptr_q[RL-1:0]][23:16];
    end
  end

  // ==========================================================================
  // Oscillator-rate tick: fractional divider, 7.37 MHz out of the bus clock.
  // Nominal rate only; accuracy and tuning spread is not modelled.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= '0;
    end else if (acc_q + FSPS_TICK_W'(FSPS_FRC_KHZ) >= FSPS_TICK_W'(FSPS_CLK_KHZ)) begin
      acc_q <= acc_q + FSPS_TICK_W'(FSPS_FRC_KHZ) - FSPS_TICK_W'(FSPS_CLK_KHZ);
    end else begin
      acc_q <= acc_q + FSPS_TICK_W'(FSPS_FRC_KHZ);
    end
  end
  assign frc_tick = (acc_q + FSPS_TICK_W'(FSPS_FRC_KHZ) >= FSPS_TICK_W'(FSPS_CLK_KHZ));

  // Duration per operation kind
  always_comb begin
    tick_lim = FSPS_TICK_W'(WORD_TICKS);
    if (kind_q == FSPS_K_ROW) tick_lim = FSPS_TICK_W'(ROW_TICKS);
    else if (kind_q == FSPS_K_PAGE) tick_lim = FSPS_TICK_W'(PAGE_TICKS);
    else if (kind_q == FSPS_K_BULK) tick_lim = FSPS_TICK_W'(BULK_TICKS);
  end
  assign done = (st_q == FSPS_WAIT) && frc_tick && (tick_cnt_q == tick_lim - 1'b1);

  // ==========================================================================
  // Sequencer: array strobes first, then the self-timed wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q          <= FSPS_IDLE;
      idx_q         <= '0;
      tick_cnt_q    <= '0;
      arr_we        <= 1'b0;
      arr_cfg       <= 1'b0;
      arr_erase     <= 1'b0;
      arr_erase_all <= 1'b0;
      arr_addr      <= '0;
      arr_wdata     <= '0;
    end else begin
      arr_we        <= 1'b0;
      arr_erase     <= 1'b0;
      arr_erase_all <= 1'b0;
      arr_cfg       <= 1'b0;    // Marks only the strobe cycle, never lingers into the next op
      case (st_q)
        FSPS_IDLE: begin
          idx_q      <= '0;
          tick_cnt_q <= '0;
          if (go_q) st_q <= FSPS_WRITE;
        end
        FSPS_WRITE: begin
          arr_cfg <= (kind_q == FSPS_K_CFG);
          if (kind_q == FSPS_K_ROW) begin
            arr_we    <= 1'b1;
            arr_addr  <= {last_q[AW-1:RL], idx_q};
            arr_wdata <= buf_q[idx_q];
            idx_q     <= idx_q + 1'b1;
            if (idx_q == RL'(FSPS_ROW_WORDS - 1)) st_q <= FSPS_WAIT;
          end else if (kind_q == FSPS_K_PAGE || kind_q == FSPS_K_BULK) begin
            arr_erase     <= 1'b1;
            arr_erase_all <= (kind_q == FSPS_K_BULK);
            arr_addr      <= {last_q[AW-1:PL], PL'(0)};
            st_q          <= FSPS_WAIT;
          end else if (kind_q == FSPS_K_CFG && erase_q) begin
            // Config byte erase is an erase strobe at the byte's own address
            arr_erase <= 1'b1;
            arr_addr  <= last_q;
            st_q      <= FSPS_WAIT;
          end else begin
            arr_we    <= 1'b1;
            arr_addr  <= last_q;
            arr_wdata <= buf_q[last_q[RL-1:0]];
            st_q      <= FSPS_WAIT;
          end
        end
        FSPS_WAIT: begin
          if (frc_tick) tick_cnt_q <= tick_cnt_q + 1'b1;
          if (done) st_q <= FSPS_IDLE;
        end
        default: st_q <= FSPS_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Checks
  go_end_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(go_q) |-> $past(st_q == FSPS_WAIT && frc_tick))
    else $error("go bit cleared outside operation end");
  stall_a: assert property (@(posedge pclk) disable iff (!presetn)
    (go_q && !done) |=> (go_q && cpu_stall && !pready))
    else $error("processor not stalled while busy");
  key_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_en && paddr == FSPS_OFS_KEY) |-> prdata == 32'h0000_0000)
    else $error("key register read nonzero");
  bad_go_a: assert property (@(posedge pclk) disable iff (!presetn)
    (go_req && key_st_q != 2'd2 && !go_q) |=> (err_q && !go_q))
    else $error("locked go did not flag error");
  inhibit_a: assert property (@(posedge pclk) disable iff (!presetn)
    (go_req && !pwdata[FSPS_CTRL_OP_WRITE_ENABLE] && !go_q) |=> !go_q ##1 !arr_we && !arr_erase)
    else $error("operation ran without write enable");
  row_len_a: assert property (@(posedge pclk) disable iff (!presetn)
    ($rose(st_q == FSPS_WAIT) && kind_q == FSPS_K_ROW) |-> idx_q == 6'h00 && arr_we &&
    arr_addr[5:0] == 6'h3F)
    else $error("row write did not cover 64 words");
  page_align_a: assert property (@(posedge pclk) disable iff (!presetn)
    (arr_erase && !arr_cfg) |-> arr_addr[8:0] == 9'h000)
    else $error("erase address not page aligned");
  tbl_only_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == FSPS_IDLE && !go_q) |=> !arr_we && !arr_erase)
    else $error("array touched outside an operation");
  tick_gap_a: assert property (@(posedge pclk) disable iff (!presetn)
    frc_tick |=> !frc_tick [*8])
    else $error("oscillator tick too frequent");
  por_only_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!other_rst_n && !wr_en && !done) |=> $stable({go_q, op_write_enable_q, erase_q, op_q}))
    else $error("control bits changed on non power-on reset");

endmodule

/* File: verification/fsps_sequencer_bench.sv */
// Self-checking testbench for the flash self-programming sequencer
`timescale 1ns/1ps

module fsps_sequencer_bench;
  import fsps_pkg::*;

  // ==========================================================================
  // Design ports and bench state
  logic        pclk;
  logic        presetn;
  logic        other_rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        cpu_stall;
  logic        arr_we;
  logic        arr_cfg;
  logic        arr_erase;
  logic        arr_erase_all;
  logic [15:0] arr_addr;
  logic [23:0] arr_wdata;
  int          num_errors;
  int          checked;
  int          cyc;
  int          n_er;
  int          n_all;
  int          n_cfg;
  int          n_stall;
  int          n_bad;
  logic [15:0] we_a[$];
  logic [23:0] we_d[$];
  logic [15:0] er_a;
  logic [23:0] buf_q[64];
  logic [15:0] last_a;

  // Short tick counts keep every timed operation but a row write to a few dozen clocks
  localparam int TK = 3;

  fsps_sequencer #(
    .ROW_TICKS (TK),
    .WORD_TICKS(TK),
    .PAGE_TICKS(TK),
    .BULK_TICKS(TK)
  ) i_dut (
    .pclk         (pclk),
    .presetn      (presetn),
    .other_rst_n  (other_rst_n),
    .psel         (psel),
    .penable      (penable),
    .pwrite       (pwrite),
    .paddr        (paddr),
    .pwdata       (pwdata),
    .prdata       (prdata),
    .pready       (pready),
    .pslverr      (pslverr),
    .cpu_stall    (cpu_stall),
    .arr_we       (arr_we),
    .arr_cfg      (arr_cfg),
    .arr_erase    (arr_erase),
    .arr_erase_all(arr_erase_all),
    .arr_addr     (arr_addr),
    .arr_wdata    (arr_wdata)
  );

  // ==========================================================================
  // Clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Array monitor; also cuts a hang short, since every wait below is open
  always @(posedge pclk) begin
    cyc++;
    if (arr_we === 1'b1) begin
      we_a.push_back(arr_addr);
      we_d.push_back(arr_wdata);
    end
    if (arr_erase === 1'b1) begin
      n_er++;
      er_a = arr_addr;
    end
    if (arr_erase_all === 1'b1) n_all++;
    if (arr_cfg === 1'b1) n_cfg++;
    if (cpu_stall === 1'b1) n_stall++;
    if ((arr_we === 1'b1 || arr_erase === 1'b1) && cpu_stall !== 1'b1) n_bad++;
    if (cpu_stall === 1'b1 && pready !== 1'b0) n_bad++;
    if (cyc == 60000) begin
      num_errors++;
      complete_run();
    end
  end

  // ==========================================================================
  // Comparisons and verdict
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp, input string what);
    checked++;
    if (got != exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ==========================================================================
  // APB master; one idle edge after release so strobes never toggle twice
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  // Fill the holding buffer for one row from its base word
  task automatic load_buf(input logic [15:0] base);
    wr(FSPS_OFS_PTR, 32'(base));
    for (int i = 0; i < 64; i++) begin
      buf_q[i] = 24'($urandom);
      wr(FSPS_OFS_TWL, 32'(buf_q[i][15:0]));
      wr(FSPS_OFS_TWH, 32'(buf_q[i][23:16]));
    end
    last_a = base + 16'd63;
  endtask

  // Unlock with the given key pair (zero means none), start, wait, read back
  task automatic run_op(input logic [15:0] ctl, input logic [15:0] keys, input logic err);
    logic [31:0] r;
    logic        e;
    wr(FSPS_OFS_CTRL, 32'h0000_0000);
    we_a.delete();
    we_d.delete();
    n_er    = 0;
    n_all   = 0;
    n_cfg   = 0;
    n_stall = 0;
    n_bad   = 0;
    if (keys != 16'h0000) begin
      wr(FSPS_OFS_KEY, 32'(keys[15:8]));
      wr(FSPS_OFS_KEY, 32'(keys[7:0]));
    end
    wr(FSPS_OFS_CTRL, 32'(ctl));
    while (cpu_stall !== 1'b0) @(posedge pclk);
    repeat (2) @(posedge pclk);
    apb(1'b0, FSPS_OFS_CTRL, 32'h0000_0000, r, e);
    chk_val(r, 32'(ctl & 16'h7FFF) | (err ? 32'h0000_2000 : 32'h0000_0000), "ctrl");
    chk_cnt(n_bad, 0, "array activity or pready outside stall");
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    logic [31:0] r;
    logic        e;
    logic [15:0] codes[9];
    int          nwe;
    int          lo;
    int          hi;
    presetn     = 1'b0;
    other_rst_n = 1'b1;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 8'h00;
    pwdata      = 32'h0000_0000;
    num_errors  = 0;
    checked     = 0;
    cyc         = 0;
    // Row, word, cfg program, page, bulk, cfg erase, two no-ops, unimplemented
    codes = '{16'hC001, 16'hC003, 16'hC000, 16'hC042, 16'hC04F,
              16'hC040, 16'hC043, 16'hC00F, 16'hC005};
    r = $urandom(32'hc883_4d24);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, FSPS_OFS_CTRL, 32'h0000_0000, r, e);
    chk_val(r, 32'(FSPS_CTRL_RESET), "ctrl reset");
    wr(FSPS_OFS_KEY, 32'h0000_FF55);
    apb(1'b0, FSPS_OFS_KEY, 32'h0000_0000, r, e);
    chk_val(r, 32'h0000_0000, "key readback");
    apb(1'b0, 8'h14, 32'h0000_0000, r, e);
    chk_val({31'h0000_0000, e}, 32'h0000_0001, "unmapped error");
    chk_val(r, 32'h0000_0000, "unmapped data");
    load_buf(16'(($urandom % 1024) * 64));
    // Pointer has stepped past the row, wrapping the buffer index to word 0
    apb(1'b0, FSPS_OFS_PTR, 32'h0000_0000, r, e);
    chk_val(r, 32'(last_a + 16'd1), "pointer after load");
    apb(1'b0, FSPS_OFS_TWL, 32'h0000_0000, r, e);
    chk_val(r, 32'(buf_q[0][15:0]), "buffer low word");
    apb(1'b0, FSPS_OFS_TWH, 32'h0000_0000, r, e);
    chk_val(r, 32'(buf_q[0][23:16]), "buffer high byte");
    // Every implemented operation, both no-ops and one unimplemented code
    for (int k = 0; k < 9; k++) begin
      if (k > 0) begin
        last_a = 16'($urandom);
        wr(FSPS_OFS_PTR, 32'(last_a));
      end
      run_op(codes[k], 16'h55AA, k == 8);
      nwe = (k == 0) ? 64 : ((k == 1 || k == 2) ? 1 : 0);
      chk_cnt(we_a.size(), nwe, "word writes");
      for (int i = 0; i < we_a.size() && i < nwe; i++) begin
        chk_val(32'(we_a[i]), 32'(k == 0 ? last_a - 16'd63 + 16'(i) : last_a), "addr");
        chk_val(32'(we_d[i]), 32'(k == 0 ? buf_q[i] : buf_q[last_a[5:0]]), "data");
      end
      chk_cnt(n_er, (k >= 3 && k <= 5) ? 1 : 0, "erase pulses");
      chk_cnt(n_all, (k == 4) ? 1 : 0, "bulk pulses");
      if (k == 3) chk_val(32'(er_a), 32'(last_a & 16'hFE00), "page base");
      if (k == 5) chk_val(32'(er_a), 32'(last_a), "config erase addr");
      chk_cnt(int'(n_cfg > 0), int'(k == 2 || k == 5), "config strobe");
      // Start edge, then 64 strobes or one, then TK ticks 13 to 14 clocks apart
      lo = ((k == 0) ? 66 : 3) + 13 * (TK - 1);
      hi = lo + 13 + TK - 1;
      chk_cnt(int'(n_stall >= lo && n_stall <= hi), int'(k < 6), "stall len");
    end
    // Improper starts: no key, keys swapped, write enable clear
    run_op(16'hC001, 16'h0000, 1'b1);
    chk_cnt(we_a.size(), 0, "writes without key");
    run_op(16'hC001, 16'hAA55, 1'b1);
    chk_cnt(we_a.size(), 0, "writes with swapped key");
    run_op(16'h8001, 16'h55AA, 1'b1);
    chk_cnt(we_a.size() + n_er, 0, "writes while inhibited");
    // A non power-on reset keeps control bits but drops the unlock
    wr(FSPS_OFS_CTRL, 32'h0000_4043);
    wr(FSPS_OFS_KEY, 32'h0000_0055);
    wr(FSPS_OFS_KEY, 32'h0000_00AA);
    other_rst_n <= 1'b0;
    repeat (2) @(posedge pclk);
    other_rst_n <= 1'b1;
    @(posedge pclk);
    apb(1'b0, FSPS_OFS_CTRL, 32'h0000_0000, r, e);
    chk_val(r, 32'h0000_4043, "ctrl after other reset");
    apb(1'b0, FSPS_OFS_PTR, 32'h0000_0000, r, e);
    chk_val(r, 32'h0000_0000, "pointer after other reset");
    wr(FSPS_OFS_CTRL, 32'h0000_C001);
    apb(1'b0, FSPS_OFS_CTRL, 32'h0000_0000, r, e);
    chk_val(r, 32'h0000_6001, "go after other reset");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, FSPS_OFS_CTRL, 32'h0000_0000, r, e);
    chk_val(r, 32'(FSPS_CTRL_RESET), "ctrl after power-on reset");
    complete_run();
  end

endmodule
